// [include/spe_regs.svh]
// Register offsets, field positions and constants of the status packet encoder
`ifndef SPE_REGS_SVH
`define SPE_REGS_SVH
`define SPE_OFF_CTRL 6'h00
`define SPE_OFF_SRC 6'h04
`define SPE_OFF_IOCFG 6'h08
`define SPE_OFF_LIM_A 6'h0C
`define SPE_OFF_LIM_MEM 6'h10
`define SPE_OFF_REV 6'h14
`define SPE_OFF_STATUS 6'h18
`define SPE_OFF_INT_STAT 6'h1C
`define SPE_OFF_INT_MASK 6'h20
`define SPE_CTRL_START 0
`define SPE_ST_FAULT 0
`define SPE_ST_BUSY 1
`define SPE_INT_DONE 0
`define SPE_INT_FAULT 1
`define SPE_INT_W 2
`define SPE_LIM_W 12
`define SPE_LIM_MAX 12'hFFF
`define SPE_DIGIT_MAX 4'h9
`define SPE_STOP_BYTE 8'h0B
`define SPE_SRC_SERIAL 3'h0
`define SPE_SRC_MEMORY 3'h1
`define SPE_SRC_CTRLPORT 3'h2
`define SPE_SRC_PANEL 3'h4
`define SPE_LIMSRC_BAD 2'h3
`define SPE_IO_ALWAYS1 2'h1
`define SPE_IO_UNUSED_HI 2'h0
`define SPE_IO_UNUSED 1'h0
`define SPE_IDX_DEC 3'h0
`define SPE_IDX_IO 3'h1
`define SPE_IDX_LIMA_LO 3'h2
`define SPE_IDX_LIMA_HI 3'h3
`define SPE_IDX_MEM_LO 3'h4
`define SPE_IDX_MEM_HI 3'h5
`define SPE_IDX_STOP1 3'h6
`define SPE_IDX_STOP2 3'h7
`define SPE_STEP_50A_UA 12210
`define SPE_STEP_60A_UA 14650
`endif

// [include/spe_pkg.sv]
// Types shared by the status packet encoder
package spe_pkg;
	typedef struct packed {
		logic [2:0] temp_src;
		logic [2:0] cur_src;
		logic [1:0] lim_src;
	} spe_src_t;
	typedef struct packed {
		logic interlock_en;
		logic shutdown_pos;
		logic shutdown_permit;
	} spe_io_t;
	typedef struct packed {
		logic [3:0] digit_second;
		logic [3:0] digit_first;
	} spe_rev_t;
	typedef enum logic {SPE_IDLE, SPE_SEND} spe_state_t;
endpackage : spe_pkg

// [design/spe_status_packet_encoder.sv]
// Status packet encoder: register slave, byte stream and interrupts
// What this block does
// - temperature source in decoder bits 7..5
// - undefined source code raises decoder fault flag
// - io byte bit0 set when shutdown permitted
// - io byte bit2 set for positive shutdown
// - io byte bit3 set while interlock enabled
// - current limits are 12-bit, 4095 steps
// - memory limit high nibble in byte 10
// - first revision digit in byte 8 upper
// - second revision digit in byte 10 upper
// - current source in decoder bits 4..2
// - packet ends with stop byte 0B twice
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "spe_regs.svh"
`default_nettype none
module spe_status_packet_encoder import spe_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic decoder_fault_error_flag
);
	// Step sizes in microamps per count; used by software scaling only
	localparam int STEP_50A_UA = `SPE_STEP_50A_UA;
	localparam int STEP_60A_UA = `SPE_STEP_60A_UA;

	function automatic logic src_ok(input logic [2:0] code);
		src_ok = (code == `SPE_SRC_SERIAL) || (code == `SPE_SRC_MEMORY) ||
			(code == `SPE_SRC_CTRLPORT) || (code == `SPE_SRC_PANEL);
	endfunction : src_ok

	function automatic logic [3:0] clamp_digit(input logic [3:0] d);
		clamp_digit = (d > `SPE_DIGIT_MAX) ? `SPE_DIGIT_MAX : d;
	endfunction : clamp_digit

	// Bits 7..6 are the fixed 0 and 1 pair, so the host can spot a misframe
	function automatic logic [7:0] io_pack(input spe_io_t io);
		io_pack = {`SPE_IO_ALWAYS1, `SPE_IO_UNUSED_HI, io.interlock_en,
			io.shutdown_pos, `SPE_IO_UNUSED, io.shutdown_permit};
	endfunction : io_pack

	spe_src_t src_reg;
	spe_io_t io_reg;
	spe_rev_t rev_reg;
	logic [11:0] lim_a_reg;
	logic [11:0] lim_mem_reg;
	logic [1:0] int_stat_reg;
	logic [1:0] int_mask_reg;
	logic [1:0] int_stat_next;
	logic [1:0] rd_clear_reg;
	spe_src_t src_snap_reg;
	spe_io_t io_snap_reg;
	spe_rev_t rev_snap_reg;
	logic [11:0] lim_a_snap_reg;
	logic [11:0] lim_mem_snap_reg;
	spe_state_t state_reg;
	logic [2:0] idx_reg;
	logic [31:0] avs_readdata_reg;
	logic avs_waitrequest_reg;
	logic irq_reg;
	logic [7:0] tx_data_reg;
	logic tx_valid_reg;
	logic fault_reg;
	logic fault_prev_reg;
	logic [31:0] rd_mux;
	logic [7:0] byte_mux;

	wire req = avs_read | avs_write;
	wire accept = req & avs_waitrequest_reg;
	wire done = req & ~avs_waitrequest_reg;
	wire wr_done = done & avs_write;
	wire rd_done = done & avs_read;
	wire sel_ctrl = (avs_address == `SPE_OFF_CTRL);
	wire sel_src = (avs_address == `SPE_OFF_SRC);
	wire sel_io = (avs_address == `SPE_OFF_IOCFG);
	wire sel_lim_a = (avs_address == `SPE_OFF_LIM_A);
	wire sel_lim_mem = (avs_address == `SPE_OFF_LIM_MEM);
	wire sel_rev = (avs_address == `SPE_OFF_REV);
	wire sel_int_stat = (avs_address == `SPE_OFF_INT_STAT);
	wire sel_int_mask = (avs_address == `SPE_OFF_INT_MASK);
	wire start = wr_done & sel_ctrl & avs_writedata[`SPE_CTRL_START] &
		(state_reg == SPE_IDLE);
	wire handshake = tx_valid_reg & tx_ready;
	wire last_byte = (idx_reg == `SPE_IDX_STOP2);
	wire pkt_done = handshake & last_byte;
	wire src_fault = (src_reg.lim_src == `SPE_LIMSRC_BAD) |
		~src_ok(src_reg.cur_src) | ~src_ok(src_reg.temp_src);
	wire fault_rise = fault_reg & ~fault_prev_reg;
	wire [2:0] idx_inc = 3'(idx_reg + 3'h1);
	wire [2:0] idx_load = start ? `SPE_IDX_DEC : idx_inc;
	wire [7:0] io_byte = io_pack(io_snap_reg);
	wire [7:0] io_byte_live = io_pack(io_reg);

	// Read mux; the start bit reads back zero, it is a command only
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_src) begin
			rd_mux[7:0] = src_reg;
		end else if (sel_io) begin
			rd_mux[7:0] = io_byte_live;
		end else if (sel_lim_a) begin
			rd_mux[11:0] = lim_a_reg;
		end else if (sel_lim_mem) begin
			rd_mux[11:0] = lim_mem_reg;
		end else if (sel_rev) begin
			rd_mux[7:0] = rev_reg;
		end else if (avs_address == `SPE_OFF_STATUS) begin
			rd_mux[`SPE_ST_FAULT] = fault_reg;
			rd_mux[`SPE_ST_BUSY] = (state_reg == SPE_SEND);
		end else if (sel_int_stat) begin
			rd_mux[1:0] = int_stat_reg;
		end else if (sel_int_mask) begin
			rd_mux[1:0] = int_mask_reg;
		end
	end

	// Byte selection from the snapshot taken at packet start
	always_comb begin
		byte_mux = `SPE_STOP_BYTE;
		case (idx_load)
			`SPE_IDX_DEC: byte_mux = start ? src_reg : src_snap_reg;
			`SPE_IDX_IO: byte_mux = io_byte;
			`SPE_IDX_LIMA_LO: byte_mux = lim_a_snap_reg[7:0];
			`SPE_IDX_LIMA_HI: byte_mux = {rev_snap_reg.digit_first,
				lim_a_snap_reg[11:8]};
			`SPE_IDX_MEM_LO: byte_mux = lim_mem_snap_reg[7:0];
			`SPE_IDX_MEM_HI: byte_mux = {rev_snap_reg.digit_second,
				lim_mem_snap_reg[11:8]};
			default: byte_mux = `SPE_STOP_BYTE;
		endcase
	end

	// Set wins over clear: only bits already returned by the read are cleared
	always_comb begin
		int_stat_next = int_stat_reg;
		if (rd_done && sel_int_stat) begin
			int_stat_next = int_stat_reg & ~rd_clear_reg;
		end
		int_stat_next[`SPE_INT_DONE] = int_stat_next[`SPE_INT_DONE] | pkt_done;
		int_stat_next[`SPE_INT_FAULT] = int_stat_next[`SPE_INT_FAULT] |
			fault_rise;
	end

	// Bus slave: one wait cycle, then the access completes
	always_ff @(posedge clk) begin
		if (reset) begin
			avs_waitrequest_reg <= 1'b1;
			avs_readdata_reg <= 32'h0000_0000;
			rd_clear_reg <= 2'h0;
		end else if (accept) begin
			avs_waitrequest_reg <= 1'b0;
			avs_readdata_reg <= rd_mux;
			rd_clear_reg <= rd_mux[1:0];
		end else begin
			avs_waitrequest_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			src_reg <= '0;
			io_reg <= '0;
			rev_reg <= '0;
			lim_a_reg <= 12'h000;
			lim_mem_reg <= 12'h000;
			int_mask_reg <= 2'h0;
		end else if (wr_done) begin
			if (sel_src) begin
				src_reg <= avs_writedata[7:0];
			end else if (sel_io) begin
				io_reg <= {avs_writedata[3], avs_writedata[2], avs_writedata[0]};
			end else if (sel_lim_a) begin
				lim_a_reg <= avs_writedata[`SPE_LIM_W-1:0];
			end else if (sel_lim_mem) begin
				lim_mem_reg <= avs_writedata[`SPE_LIM_W-1:0];
			end else if (sel_rev) begin
				rev_reg.digit_first <= clamp_digit(avs_writedata[3:0]);
				rev_reg.digit_second <= clamp_digit(avs_writedata[7:4]);
			end else if (sel_int_mask) begin
				int_mask_reg <= avs_writedata[`SPE_INT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			int_stat_reg <= 2'h0;
			irq_reg <= 1'b0;
			fault_reg <= 1'b0;
			fault_prev_reg <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			irq_reg <= |(int_stat_next & int_mask_reg);
			fault_reg <= src_fault;
			fault_prev_reg <= fault_reg;
		end
	end

	// Snapshot keeps one packet coherent while software rewrites registers
	always_ff @(posedge clk) begin
		if (reset) begin
			src_snap_reg <= '0;
			io_snap_reg <= '0;
			rev_snap_reg <= '0;
			lim_a_snap_reg <= 12'h000;
			lim_mem_snap_reg <= 12'h000;
		end else if (start) begin
			src_snap_reg <= src_reg;
			io_snap_reg <= io_reg;
			rev_snap_reg <= rev_reg;
			lim_a_snap_reg <= lim_a_reg;
			lim_mem_snap_reg <= lim_mem_reg;
		end
	end

	// Stream: data held steady until the sink takes it
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= SPE_IDLE;
			idx_reg <= `SPE_IDX_DEC;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end else begin
			case (state_reg)
				SPE_IDLE: begin
					if (start) begin
						state_reg <= SPE_SEND;
						idx_reg <= `SPE_IDX_DEC;
						tx_valid_reg <= 1'b1;
						tx_data_reg <= byte_mux;
					end
				end
				SPE_SEND: begin
					if (pkt_done) begin
						state_reg <= SPE_IDLE;
						tx_valid_reg <= 1'b0;
					end else if (handshake) begin
						idx_reg <= idx_inc;
						tx_data_reg <= byte_mux;
					end
				end
				default: state_reg <= SPE_IDLE;
			endcase
		end
	end

	assign avs_readdata = avs_readdata_reg;
	assign avs_waitrequest = avs_waitrequest_reg;
	assign irq = irq_reg;
	assign tx_data = tx_data_reg;
	assign tx_valid = tx_valid_reg;
	assign decoder_fault_error_flag = fault_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_TEMP_SRC: assert property (tx_valid && idx_reg == `SPE_IDX_DEC |->
		tx_data[7:5] == src_snap_reg.temp_src) else $error("temp source bits");
	AST_CUR_SRC: assert property (tx_valid && idx_reg == `SPE_IDX_DEC |->
		tx_data[4:2] == src_snap_reg.cur_src) else $error("current source bits");
	AST_FAULT: assert property (src_fault ##1 src_fault |->
		decoder_fault_error_flag) else $error("fault flag not set");
	AST_NO_FAULT: assert property (!$past(src_fault) |->
		!decoder_fault_error_flag) else $error("spurious fault flag");
	AST_IO_FIXED: assert property (tx_valid && idx_reg == `SPE_IDX_IO |->
		tx_data[7:6] == 2'h1 && tx_data[5:4] == 2'h0 && !tx_data[1])
		else $error("io fixed bits");
	AST_IO_BITS: assert property (tx_valid &&
		idx_reg == `SPE_IDX_IO |->
		tx_data[0] == io_snap_reg.shutdown_permit &&
		tx_data[2] == io_snap_reg.shutdown_pos &&
		tx_data[3] == io_snap_reg.interlock_en) else $error("io flag bits");
	AST_REV1: assert property (tx_valid && idx_reg == `SPE_IDX_LIMA_HI |->
		tx_data[7:4] == rev_snap_reg.digit_first && tx_data[7:4] <= 4'h9)
		else $error("first digit");
	AST_MEM_HI: assert property (tx_valid && idx_reg == `SPE_IDX_MEM_HI |->
		tx_data == {rev_snap_reg.digit_second, lim_mem_snap_reg[11:8]})
		else $error("byte 10 layout");
	AST_STOP: assert property (handshake &&
		idx_reg == `SPE_IDX_MEM_HI |=> tx_valid &&
		tx_data == `SPE_STOP_BYTE) else $error("first stop byte");
	AST_STOP2: assert property (handshake &&
		idx_reg == `SPE_IDX_STOP1 |=> tx_valid &&
		idx_reg == `SPE_IDX_STOP2 && tx_data == `SPE_STOP_BYTE)
		else $error("second stop byte");
	AST_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("stream data not held");
	AST_MEM_LO: assert property (tx_valid &&
		idx_reg == `SPE_IDX_MEM_LO |-> tx_data == lim_mem_snap_reg[7:0])
		else $error("memory limit low byte");
	AST_DONE: assert property (pkt_done |=> !tx_valid &&
		int_stat_reg[`SPE_INT_DONE]) else $error("packet end");
	AST_SNAP: assert property (start |=> io_snap_reg == $past(io_reg) &&
		src_snap_reg == $past(src_reg)) else $error("packet snapshot");
	AST_IRQ: assert property (irq == |(int_stat_reg & $past(int_mask_reg)))
		else $error("irq level");
endmodule : spe_status_packet_encoder
`default_nettype wire

// [verification/spe_host_model.sv]
// Host-side model that takes packet bytes off the encoder stream
`timescale 1ns/1ps
`default_nettype none
module spe_host_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic clear,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [63:0] frame,
	output logic [3:0] count,
	output logic frame_end
);
	logic [7:0] last_reg;
	wire logic take;
	assign take = tx_valid && tx_ready;
	// A slow host accepts every other cycle, so the byte must be held
	always_ff @(posedge clk) begin
		if (reset || clear) begin
			tx_ready <= 1'b0;
			count <= 4'h0;
			frame <= 64'h0;
			frame_end <= 1'b0;
			last_reg <= 8'h00;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (take) begin
				frame[8 * count[2:0] +: 8] <= tx_data;
				count <= count + 4'h1;
				last_reg <= tx_data;
				frame_end <= (tx_data == 8'h0B) && (last_reg == 8'h0B);
			end
		end
	end
endmodule : spe_host_model
`default_nettype wire

// [verification/test_status_packet_encoder.sv]
// Testbench for the status packet encoder: bus tasks and packet checks
`timescale 1ns/1ps
`include "spe_regs.svh"
`default_nettype none
module test_status_packet_encoder import spe_pkg::*;;
	logic clk, reset, avs_read, avs_write, avs_waitrequest, irq;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic [7:0] tx_data;
	logic tx_valid, tx_ready, flag, slow, clear, frame_end, e;
	logic [63:0] frame;
	logic [3:0] count;
	int failures, cmp_count, cyc;
	spe_status_packet_encoder i_spe_status_packet_encoder (.clk(clk),
		.reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .decoder_fault_error_flag(flag));
	spe_host_model i_spe_host_model (.clk(clk), .reset(reset), .slow(slow),
		.clear(clear), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .frame(frame), .count(count),
		.frame_end(frame_end));
	always #4 clk = ~clk;
	task automatic report_and_stop;
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop;
		end
	end
	task automatic check(input string nm, input logic [63:0] ex,
		input logic [63:0] g);
		cmp_count++;
		if (g !== ex) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, ex, g);
		end
	endtask : check
	// Request held until waitrequest is sampled low; released at that edge, task returns one edge later
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [31:0] ex);
		bus(1'b0, a, 32'h0);
		check("readdata", ex, rdata);
	endtask : rd
	task automatic wait_frame;
		for (int n = 0; n < 200 && count !== 4'h8; n++)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask : wait_frame
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		slow = 1'b1;
		clear = 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(`SPE_OFF_STATUS, 32'h0);
		rd(`SPE_OFF_IOCFG, 32'h40);
		rd(6'h3C, 32'h0);
		check("irq", 1'b0, irq);
		bus(1'b1, `SPE_OFF_INT_MASK, 32'h3);
		bus(1'b1, `SPE_OFF_SRC, 32'h89);
		bus(1'b1, `SPE_OFF_IOCFG, 32'h0D);
		rd(`SPE_OFF_IOCFG, 32'h4D);
		bus(1'b1, `SPE_OFF_LIM_A, 32'hABC);
		bus(1'b1, `SPE_OFF_LIM_MEM, 32'h5E7);
		bus(1'b1, `SPE_OFF_REV, 32'hAF);
		rd(`SPE_OFF_REV, 32'h99);
		bus(1'b1, `SPE_OFF_REV, 32'h37);
		bus(1'b1, `SPE_OFF_CTRL, 32'h1);
		wait_frame;
		check("frame", 64'h0B0B35E77ABC4D89, frame);
		check("frame_end", 1'b1, frame_end);
		check("tx_valid", 1'b0, tx_valid);
		check("irq", 1'b1, irq);
		rd(`SPE_OFF_INT_STAT, 32'h1);
		rd(`SPE_OFF_INT_STAT, 32'h0);
		check("irq", 1'b0, irq);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		slow <= 1'b0;
		bus(1'b1, `SPE_OFF_SRC, 32'h0);
		bus(1'b1, `SPE_OFF_CTRL, 32'h1);
		bus(1'b1, `SPE_OFF_CTRL, 32'h1);
		wait_frame;
		repeat (20) @(posedge clk);
		check("count", 4'h8, count);
		check("frame", 64'h0B0B35E77ABC4D00, frame);
		rd(`SPE_OFF_INT_STAT, 32'h1);
		for (int i = 0; i < 8; i++) begin
			e = !(i inside {0, 1, 2, 4});
			bus(1'b1, `SPE_OFF_SRC, 32'(i) << 5);
			rd(`SPE_OFF_STATUS, {31'h0, e});
			check("flag", e, flag);
			bus(1'b1, `SPE_OFF_SRC, 32'(i) << 2);
			rd(`SPE_OFF_STATUS, {31'h0, e});
		end
		bus(1'b1, `SPE_OFF_SRC, 32'h3);
		rd(`SPE_OFF_STATUS, 32'h1);
		check("irq", 1'b1, irq);
		rd(`SPE_OFF_INT_STAT, 32'h2);
		bus(1'b1, `SPE_OFF_SRC, 32'h0);
		rd(`SPE_OFF_STATUS, 32'h0);
		check("flag", 1'b0, flag);
		rd(`SPE_OFF_INT_STAT, 32'h0);
		check("irq", 1'b0, irq);
		report_and_stop;
	end
endmodule : test_status_packet_encoder
`default_nettype wire
